// [tbs_pkg.sv]
package tbs_pkg;
  localparam int unsigned CHAR_W = 10;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned LINK_PERIOD_NS = 125;
  localparam int unsigned BIT_TICKS = LINK_PERIOD_NS * CLK_MHZ / 1000 / 10;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'h9;
  localparam logic [6:0] COMMA_POS = 7'h7c;
  localparam logic [6:0] COMMA_NEG = 7'h03;
  localparam int unsigned COMMA_BITS = 7;
  localparam int unsigned LOCK_BITS = 1400;
  localparam int unsigned SIG_TIMEOUT_BITS = 64;
  localparam int unsigned ECHO_LAG = 4;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] ADDR_MASK = 32'h0000_0004;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0008;
  localparam logic [31:0] ADDR_RXWORD = 32'h0000_000c;
  localparam int unsigned EV_COMMA = 0;
  localparam int unsigned EV_SIG_LOST = 1;
  localparam int unsigned EV_SIG_GAIN = 2;
  localparam int unsigned EV_W = 3;
  localparam int unsigned CTRL_LOOP = 0;
  localparam int unsigned CTRL_ALIGN = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [CHAR_W-1:0] word;
    logic comma;
  } tbs_rx_t;
endpackage : tbs_pkg

// [tbs_serdes.sv]
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tbs_serdes (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_ref_clock,
  input wire logic [9:0] tx_char,
  input wire logic loopback_pin,
  input wire logic comma_align_pin,
  input wire logic rx_serial_p,
  output logic tx_serial_p,
  output logic tx_serial_n,
  output logic rx_clk_true,
  output logic rx_clk_comp,
  output logic [9:0] rx_word,
  output logic comma_found,
  output logic line_signal_present,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned BT = (tbs_pkg::BIT_TICKS < 1) ? 1 : tbs_pkg::BIT_TICKS;
  localparam int unsigned TW = $clog2(BT + 1);
  localparam logic [TW-1:0] BT_LAST = TW'(BT - 1);
  localparam logic [3:0] SLOTS = 4'(tbs_pkg::CHAR_W);
  localparam logic [3:0] COMMA_PRE = 4'(tbs_pkg::COMMA_BITS - 1);
  localparam logic [3:0] COMMA_END = 4'(tbs_pkg::COMMA_BITS);

  // ==========================================================
  // input synchronisers
  logic [1:0] ref_s_r, loop_s_r, align_s_r, rx_s_r;
  logic [9:0] tchar_s1_r, tchar_s2_r;
  logic ref_d_r;
  always_ff @(posedge aclk)
  begin
    ref_s_r <= {ref_s_r[0], tx_ref_clock};
    loop_s_r <= {loop_s_r[0], loopback_pin};
    align_s_r <= {align_s_r[0], comma_align_pin};
    rx_s_r <= {rx_s_r[0], rx_serial_p};
    tchar_s1_r <= tx_char;
    tchar_s2_r <= tchar_s1_r;
    ref_d_r <= ref_s_r[1];
  end
  logic ref_rise, loop_on, align_on, ctrl_loop_r, ctrl_align_r;
  assign ref_rise = ref_s_r[1] & ~ref_d_r;
  assign loop_on = loop_s_r[1] | ctrl_loop_r;
  assign align_on = align_s_r[1] | ctrl_align_r;

  // ==========================================================
  // bit clock: ten bit enables per reference period
  logic [TW-1:0] tick_r;
  logic [3:0] slot_r;
  logic bit_en;
  assign bit_en = (tick_r == BT_LAST) && !ref_rise && (slot_r != SLOTS);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ref_rise)
      tick_r <= '0;
    else if (tick_r == BT_LAST)
      tick_r <= '0;
    else
      tick_r <= tick_r + TW'(1);
  end
  // ten slots per reference period, then idle until the next rise
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ref_rise)
      slot_r <= '0;
    else if (bit_en)
      slot_r <= slot_r + 4'h1;
  end
  // external bits arrive late: output flop, line flop, two sync flops
  logic [tbs_pkg::ECHO_LAG-1:0] en_d_r;
  logic rx_en;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      en_d_r <= '0;
    else
      en_d_r <= {en_d_r[tbs_pkg::ECHO_LAG-2:0], bit_en};
  end
  assign rx_en = loop_on ? bit_en : en_d_r[tbs_pkg::ECHO_LAG-1];

  // ==========================================================
  // transmitter
  logic [9:0] tx_hold_r, tx_shift_r;
  logic [3:0] tx_cnt_r;
  logic tx_bit_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_hold_r <= '0;
    else if (ref_rise)
      tx_hold_r <= tchar_s2_r;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_shift_r <= '0;
      tx_cnt_r <= '0;
      tx_bit_r <= 1'b0;
    end
    else if (ref_rise)
    begin
      tx_shift_r <= {1'b0, tx_hold_r[9:1]};
      tx_bit_r <= tx_hold_r[0];
      tx_cnt_r <= '0;
    end
    else if (bit_en && tx_cnt_r != tbs_pkg::LAST_BIT)
    begin
      tx_bit_r <= tx_shift_r[0];
      tx_shift_r <= {1'b0, tx_shift_r[9:1]};
      tx_cnt_r <= tx_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_serial_p <= 1'b1;
      tx_serial_n <= 1'b0;
    end
    else if (loop_on)
    begin
      tx_serial_p <= 1'b1;
      tx_serial_n <= 1'b0;
    end
    else
    begin
      tx_serial_p <= tx_bit_r;
      tx_serial_n <= ~tx_bit_r;
    end
  end

  // ==========================================================
  // receiver: shift, align, word out
  logic rx_bit;
  assign rx_bit = loop_on ? tx_bit_r : rx_s_r[1];
  logic [9:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic rx_phase_r, rx_comma_r;
  logic [6:0] next7;
  assign next7 = {rx_bit, rx_sh_r[9:4]};
  function automatic logic is_comma(input logic [6:0] v);
    is_comma = (v == tbs_pkg::COMMA_POS) || (v == tbs_pkg::COMMA_NEG);
  endfunction : is_comma
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
      rx_word <= '0;
      rx_phase_r <= 1'b0;
      rx_comma_r <= 1'b0;
    end
    else if (rx_en)
    begin
      rx_sh_r <= {rx_bit, rx_sh_r[9:1]};
      if (align_on && is_comma(next7) && rx_cnt_r != COMMA_PRE)
        rx_cnt_r <= COMMA_END;
      else if (rx_cnt_r == tbs_pkg::LAST_BIT)
        rx_cnt_r <= '0;
      else
        rx_cnt_r <= rx_cnt_r + 4'h1;
      if (rx_cnt_r == tbs_pkg::LAST_BIT)
      begin
        rx_word <= {rx_bit, rx_sh_r[9:1]};
        rx_phase_r <= ~rx_phase_r;
        rx_comma_r <= align_on && is_comma(rx_sh_r[7:1]);
      end
    end
  end
  // comma only on words launched by the complementary clock
  assign rx_clk_true = rx_phase_r;
  assign rx_clk_comp = ~rx_phase_r;
  assign comma_found = rx_comma_r & ~rx_phase_r & align_on;

  // ==========================================================
  // signal detect: transitions seen within a window
  logic [6:0] quiet_r;
  logic rx_prev_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      quiet_r <= 7'(tbs_pkg::SIG_TIMEOUT_BITS);
      rx_prev_r <= 1'b0;
      line_signal_present <= 1'b0;
    end
    else if (rx_en)
    begin
      rx_prev_r <= rx_bit;
      if (rx_bit != rx_prev_r)
        quiet_r <= '0;
      else if (quiet_r != 7'(tbs_pkg::SIG_TIMEOUT_BITS))
        quiet_r <= quiet_r + 7'h01;
      line_signal_present <= (quiet_r != 7'(tbs_pkg::SIG_TIMEOUT_BITS));
    end
  end
  logic sig_d_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sig_d_r <= 1'b0;
    else
      sig_d_r <= line_signal_present;
  end

  // ==========================================================
  // interrupts
  logic [tbs_pkg::EV_W-1:0] ev, stat_r, mask_r, w1c;
  logic comma_d_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      comma_d_r <= 1'b0;
    else
      comma_d_r <= comma_found;
  end
  assign ev[tbs_pkg::EV_COMMA] = comma_found & ~comma_d_r;
  assign ev[tbs_pkg::EV_SIG_LOST] = sig_d_r & ~line_signal_present;
  assign ev[tbs_pkg::EV_SIG_GAIN] = ~sig_d_r & line_signal_present;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_r <= '0;
    else
      stat_r <= (stat_r & ~w1c) | ev;
  end
  assign irq = |(stat_r & mask_r);

  // ==========================================================
  // axi4-lite slave
  logic [31:0] awaddr_r, wdata_r;
  logic aw_have_r, w_have_r;
  logic do_write;
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign w1c = (do_write && awaddr_r == tbs_pkg::ADDR_STATUS)
    ? wdata_r[tbs_pkg::EV_W-1:0] : '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tbs_pkg::RESP_OKAY;
      mask_r <= '0;
      ctrl_loop_r <= 1'b0;
      ctrl_align_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (do_write)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= tbs_pkg::RESP_OKAY;
        unique case (awaddr_r)
          tbs_pkg::ADDR_STATUS, tbs_pkg::ADDR_RXWORD: ;
          tbs_pkg::ADDR_MASK: mask_r <= wdata_r[tbs_pkg::EV_W-1:0];
          tbs_pkg::ADDR_CTRL:
          begin
            ctrl_loop_r <= wdata_r[tbs_pkg::CTRL_LOOP];
            ctrl_align_r <= wdata_r[tbs_pkg::CTRL_ALIGN];
          end
          default: s_axi_bresp <= tbs_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tbs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= tbs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        tbs_pkg::ADDR_STATUS: s_axi_rdata <= 32'(stat_r);
        tbs_pkg::ADDR_MASK: s_axi_rdata <= 32'(mask_r);
        tbs_pkg::ADDR_CTRL: s_axi_rdata <= {30'h0000_0000, ctrl_align_r, ctrl_loop_r};
        tbs_pkg::ADDR_RXWORD: s_axi_rdata <= {21'h00_0000, line_signal_present, rx_word};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= tbs_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // checks
  a_loop_park: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(loop_on) |-> tx_serial_p && !tx_serial_n) else $error("loopback not parked");
  a_comma_comp: assert property (@(posedge aclk) disable iff (!aresetn)
    comma_found |-> rx_clk_comp && is_comma(rx_word[6:0])) else $error("comma flag wrong");
  a_comma_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !align_on |-> !comma_found) else $error("comma while disabled");
  a_clk_compl: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_clk_true != rx_clk_comp) else $error("clocks not complementary");
  a_word_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(rx_word) |-> $changed(rx_clk_true)) else $error("word off edge");
  a_tx_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_rise |=> tx_bit_r == $past(tx_hold_r[0])) else $error("first bit wrong");
  a_ten_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    ref_rise |-> ##10 (tx_cnt_r == tbs_pkg::LAST_BIT)) else $error("bit count wrong");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(stat_r & mask_r)) else $error("irq mismatch");
  a_stat_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ev[tbs_pkg::EV_COMMA] |=> stat_r[tbs_pkg::EV_COMMA]) else $error("event lost");
endmodule : tbs_serdes

// [tbs_ctrl_model.sv]
`timescale 1ns/1ps
module tbs_ctrl_model (
  input wire logic [9:0] next_char,
  output logic tx_ref_clock,
  output logic [9:0] tx_char
);
  // ==========================================
  // free-running reference, phase unrelated to aclk
  initial
  begin
    tx_ref_clock = 1'b0;
    tx_char = 10'h000;
    #3.3;
    forever
    begin
      #62.5 tx_ref_clock = ~tx_ref_clock;
    end
  end
  // character changes at the falling edge, stable at the rising edge
  always @(negedge tx_ref_clock) tx_char <= next_char;
endmodule : tbs_ctrl_model

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // signals
  logic aclk;
  logic aresetn = 1'b0;
  logic ref_clk;
  logic [9:0] tx_char;
  logic [9:0] chr = 10'h17c;
  logic loop_pin = 1'b0;
  logic align_pin = 1'b0;
  logic rx_ser = 1'b1;
  logic rx_tie = 1'b0;
  logic tx_p, tx_n, clk_t, clk_c, comma_found, sig_ok, irq;
  logic [9:0] rx_word;
  logic [31:0] aw_addr = 32'h0000_0000;
  logic [31:0] w_data = 32'h0000_0000;
  logic [31:0] ar_addr = 32'h0000_0000;
  logic [31:0] r_data;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp, got_resp;
  logic [31:0] got;
  int n_checks = 0;
  int n_mismatch = 0;
  int n_comma = 0;
  int n_bad = 0;
  int c0;

  initial
  begin
    aclk = 1'b0;
    forever
    begin
      #5 aclk = ~aclk;
    end
  end

  tbs_ctrl_model u_ctrl (.next_char(chr), .tx_ref_clock(ref_clk), .tx_char(tx_char));

  tbs_serdes u_dut (
    .aclk(aclk), .aresetn(aresetn), .tx_ref_clock(ref_clk), .tx_char(tx_char),
    .loopback_pin(loop_pin), .comma_align_pin(align_pin), .rx_serial_p(rx_ser),
    .tx_serial_p(tx_p), .tx_serial_n(tx_n), .rx_clk_true(clk_t), .rx_clk_comp(clk_c),
    .rx_word(rx_word), .comma_found(comma_found), .line_signal_present(sig_ok), .irq(irq),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready)
  );

  // external line from own transmitter, or held low for loss of signal
  always @(posedge aclk)
  begin
    rx_ser <= rx_tie ? 1'b0 : tx_p;
    if (comma_found === 1'b1)
      n_comma <= n_comma + 1;
    if ((comma_found === 1'b1 && clk_c !== 1'b1) || clk_c !== ~clk_t)
      n_bad <= n_bad + 1;
  end

  // ==========================================
  // tasks
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok, b_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    while (!b_ok && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (aw_valid && aw_ready === 1'b1)
      begin
        aw_ok = 1'b1;
        aw_valid <= 1'b0;
      end
      if (w_valid && w_ready === 1'b1)
      begin
        w_ok = 1'b1;
        w_valid <= 1'b0;
      end
      if (b_valid === 1'b1)
        b_ok = 1'b1;
    end
    if (!b_ok || !aw_ok || !w_ok)
    begin
      n_mismatch++;
      final_report();
    end
  endtask : axi_wr

  task axi_rd(input logic [31:0] a);
    int n;
    logic r_ok;
    n = 0;
    r_ok = 1'b0;
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    while (!r_ok && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (ar_valid && ar_ready === 1'b1)
        ar_valid <= 1'b0;
      if (r_valid === 1'b1)
      begin
        r_ok = 1'b1;
        got = r_data;
        got_resp = r_resp;
      end
    end
    if (!r_ok)
    begin
      n_mismatch++;
      final_report();
    end
  endtask : axi_rd

  // ==========================================
  // sequence
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(tbs_pkg::ADDR_MASK);
    chk(got, 32'h0000_0000);
    axi_rd(tbs_pkg::ADDR_CTRL);
    chk(got, 32'h0000_0000);
    axi_rd(32'h0000_0010);
    chk({got_resp, got[29:0]}, {tbs_pkg::RESP_SLVERR, 30'h0000_0000});
    loop_pin <= 1'b1;
    rx_tie <= 1'b1;
    c0 = n_comma;
    repeat (200) @(posedge aclk);
    chk({30'h0000_0000, tx_p, tx_n}, 32'h0000_0002);
    chk(n_comma - c0, 0);
    loop_pin <= 1'b0;
    axi_wr(tbs_pkg::ADDR_CTRL, 32'h0000_0003);
    repeat (400) @(posedge aclk);
    chk(n_comma > c0, 1);
    axi_rd(tbs_pkg::ADDR_RXWORD);
    chk(got & 32'h0000_03ff, 32'h0000_017c);
    axi_wr(tbs_pkg::ADDR_STATUS, 32'h0000_0007);
    axi_wr(tbs_pkg::ADDR_MASK, 32'h0000_0001);
    repeat (50) @(posedge aclk);
    chk(irq, 1'b1);
    chr <= 10'h2aa;
    repeat (100) @(posedge aclk);
    axi_wr(tbs_pkg::ADDR_STATUS, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    axi_rd(tbs_pkg::ADDR_STATUS);
    chk(got & 32'h0000_0001, 32'h0000_0000);
    align_pin <= 1'b1;
    rx_tie <= 1'b0;
    chr <= 10'h17c;
    axi_wr(tbs_pkg::ADDR_CTRL, 32'h0000_0000);
    repeat (400) @(posedge aclk);
    axi_rd(tbs_pkg::ADDR_RXWORD);
    chk(got, 32'h0000_057c);
    rx_tie <= 1'b1;
    repeat (150) @(posedge aclk);
    chk(sig_ok, 1'b0);
    axi_rd(tbs_pkg::ADDR_STATUS);
    chk(got & 32'h0000_0002, 32'h0000_0002);
    chk(n_bad, 0);
    final_report();
  end
endmodule : testbench
